// >>> shared/wdt_defines.svh
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// byte addresses on the APB side
`define WDT_CSR_ADDR 12'h060
`define WDT_CAUSE_ADDR 12'h064
`define WDT_PROTECT_ADDR 12'h068

// watchdog_control_status field positions
`define WDT_BIT_IRQ_FLAG 7
`define WDT_BIT_IRQ_EN 6
`define WDT_BIT_PER_HI 5
`define WDT_BIT_EN 3
`define WDT_PER_LO_MSB 2

// reset_cause_status field positions
`define WDT_BIT_WATCHDOG_RESET_FLAG 3
`define WDT_BIT_BROWNOUT_RESET_FLAG 2
`define WDT_BIT_PIN_RESET_FLAG 1
`define WDT_BIT_POWERON_RESET_FLAG 0

// reset values
`define WDT_CSR_RESET 8'h00
`define WDT_CAUSE_RESET 8'h01

// change protection
`define WDT_UNLOCK_SIG 8'hD8
`define WDT_UNLOCK_CYCLES 3'h4

// time-out periods in oscillator cycles: base shifted by the code
`define WDT_BASE_CYCLES 19'h00200
`define WDT_PERIOD_MAX_CODE 4'h9
`define WDT_PERIOD_FALLBACK 4'h0

`endif

// >>> shared/wdt_pkg.sv
package wdt_pkg;

	typedef struct packed {
		logic irq_flag;
		logic irq_en;
		logic per_hi;
		logic rsvd;
		logic en;
		logic [2:0] per_lo;
	} wdt_csr_t;

	typedef struct packed {
		logic [3:0] rsvd;
		logic watchdog_reset_flag;
		logic brownout_reset_flag;
		logic pin_reset_flag;
		logic poweron_reset_flag;
	} reset_cause_t;

	typedef enum logic [1:0] {
		ACTION_NONE,
		ACTION_IRQ,
		ACTION_RESET
	} timeout_action_t;

endpackage : wdt_pkg

// >>> verilog/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
	input wire logic pclk, // bus clock
	input wire logic presetn, // async reset, active low
	input wire logic pin, // asynchronous input
	output logic level, // debounced level
	output logic rise // one-cycle pulse on a 0 to 1 change
);

	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// a change counts only once the second and third stage agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level <= 1'b0;
			rise <= 1'b0;
		end else begin
			rise <= (s2 == s3) && s2 && !level;
			if (s2 == s3) begin
				level <= s2;
			end
		end
	end

endmodule : pin_sync

`default_nettype wire

// >>> verilog/watchdog_with_reset_flags.sv
// How it works
// [R01] counter advances on 32 kHz oscillator edges
// [R02] restart, disable and chip reset clear counter
// [R03] ten time-out periods from period_select
// [R04] expiry with reset action resets the chip
// [R05] level 1: starts off, enable freely
// [R06] level 2: always running, enable reads one
// [R07] level 1 disable needs unlock then write
// [R08] level 2 period change needs unlock; enable ignored
// [R09] software unlocks with signature 0xD8
// [R10] reserved bits read as zero
// [R11] watchdog flag: set on expiry, zero-write clears
// [R12] brown-out flag: set on brown-out, zero-write clears
// [R13] pin flag: set on pin reset, zero-write clears
// [R14] power-on flag: set at power-on, zero-write clears
// [R15] irq flag set on time-out, ack clears
// [R16] irq needs global, enable and flag set
// [R17] time-out with enable clears irq enable
// [R18] enable and irq-enable select time-out action
// [R19] enable bit starts and stops the timer
// [R20] level 2 never allows disabling
// [R21] level 1: watchdog flag forces enable on
// [R22] init software clears watchdog flag and enable
// [R23] codes double 512 to 256K; reserved falls back
// [R24] unlock window closes after four cycles
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

`include "wdt_defines.svh"

module watchdog_with_reset_flags (
	input wire logic pclk, // 40 MHz bus clock
	input wire logic presetn, // power-on reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction, 1 = write
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic osc_32k, // low-power oscillator pin
	input wire logic safety_level_fuse, // high = programmed, level 2
	input wire logic restart_pulse, // restart instruction, one cycle
	input wire logic global_irq_enable, // I-bit of cpu_status_register
	input wire logic irq_vector_ack, // time-out vector taken, one cycle
	input wire logic brownout_reset, // brown-out reset level
	input wire logic pin_reset, // external pin reset level
	output wdt_pkg::reset_cause_t cause_flags, // reset_cause_status contents
	output logic timeout_irq, // interrupt request, level
	output logic watchdog_reset_out // chip reset request, one cycle
);

	import wdt_pkg::*;

	wdt_csr_t csr;
	timeout_action_t action;
	logic osc_rise;
	logic level2;
	logic bor_rise;
	logic pin_rise;
	logic [2:0] unlock_cnt;
	logic unlock_open;
	logic [17:0] count;
	logic [17:0] terminal;
	logic [3:0] period_sel;
	logic [3:0] period_eff;
	logic enable_eff;
	logic running;
	logic timeout;
	logic wdt_fire;
	logic chip_reset;
	logic setup_phase;
	logic wr_done;
	logic wr_csr;
	logic wr_cause;
	logic wr_protect;
	logic mapped;
	logic [7:0] wdata;
	logic [7:0] read_byte;

	// every asynchronous level goes through the same three-stage filter
	pin_sync osc_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin(osc_32k),
		.level(),
		.rise(osc_rise)
	);

	pin_sync fuse_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin(safety_level_fuse),
		.level(level2),
		.rise()
	);

	pin_sync bor_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin(brownout_reset),
		.level(),
		.rise(bor_rise)
	);

	pin_sync pin_rst_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin(pin_reset),
		.level(),
		.rise(pin_rise)
	);

	// bus decode; writes take effect on the access edge with pready high
	assign setup_phase = psel && !penable;
	assign wr_done = psel && penable && pready && pwrite && pstrb[0];
	assign wdata = pwdata[7:0];
	assign wr_csr = wr_done && (paddr == `WDT_CSR_ADDR);
	assign wr_cause = wr_done && (paddr == `WDT_CAUSE_ADDR);
	assign wr_protect = wr_done && (paddr == `WDT_PROTECT_ADDR);
	assign mapped = (paddr == `WDT_CSR_ADDR) || (paddr == `WDT_CAUSE_ADDR) || (paddr == `WDT_PROTECT_ADDR);

	// effective enable: fuse and the watchdog flag both pin it high
	assign enable_eff = level2 || csr.en || (!level2 && cause_flags.watchdog_reset_flag); // [R06] [R21] [R19]

	// both bits clear is the only stopped state
	always_comb begin
		unique case ({enable_eff, csr.irq_en}) // [R18]
			2'b00: action = ACTION_NONE;
			2'b01: action = ACTION_IRQ;
			2'b10: action = ACTION_RESET;
			2'b11: action = ACTION_IRQ;
		endcase
	end

	assign running = (action != ACTION_NONE);

	// reserved codes are not trusted to decode; they take the shortest period
	assign period_sel = {csr.per_hi, csr.per_lo};
	assign period_eff = (period_sel > `WDT_PERIOD_MAX_CODE) ? `WDT_PERIOD_FALLBACK : period_sel; // [R23]
	assign terminal = 18'((`WDT_BASE_CYCLES << period_eff) - 19'h00001); // [R03] [R23]

	// a period shortened below the running count expires at the next edge instead of wrapping
	assign timeout = running && osc_rise && (count >= terminal);
	assign wdt_fire = timeout && (action == ACTION_RESET); // [R04]
	assign chip_reset = wdt_fire || bor_rise || pin_rise;

	// time-out counter, one step per oscillator edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 18'h00000;
		end else if (chip_reset || restart_pulse || !running) begin
			count <= 18'h00000; // [R02]
		end else if (osc_rise) begin
			if (count >= terminal) begin
				count <= 18'h00000;
			end else begin
				count <= count + 18'h00001; // [R01]
			end
		end
	end

	// unlock window, counted in bus clock (pclk) cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unlock_cnt <= 3'h0;
		end else if (wr_protect && (wdata == `WDT_UNLOCK_SIG)) begin
			unlock_cnt <= `WDT_UNLOCK_CYCLES; // [R09]
		end else if (wr_csr) begin
			unlock_cnt <= 3'h0;
		end else if (unlock_cnt != 3'h0) begin
			unlock_cnt <= unlock_cnt - 3'h1; // [R24]
		end
	end

	assign unlock_open = (unlock_cnt != 3'h0);

	// control register: a chip reset returns it to its initial value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			csr <= `WDT_CSR_RESET; // [R05]
		end else if (chip_reset) begin
			csr <= `WDT_CSR_RESET;
		end else begin
			// set beats both clears so a time-out never goes missing
			if (timeout && action == ACTION_IRQ) begin
				csr.irq_flag <= 1'b1; // [R15]
			end else if (irq_vector_ack || (wr_csr && wdata[`WDT_BIT_IRQ_FLAG])) begin
				csr.irq_flag <= 1'b0; // [R15]
			end
			if (timeout && enable_eff) begin
				csr.irq_en <= 1'b0; // [R17]
			end else if (wr_csr) begin
				csr.irq_en <= wdata[`WDT_BIT_IRQ_EN];
			end
			if (wr_csr && (!level2 || unlock_open)) begin
				csr.per_hi <= wdata[`WDT_BIT_PER_HI]; // [R08]
				csr.per_lo <= wdata[`WDT_PER_LO_MSB:0];
			end
			// at level 2 the stored enable is never touched
			if (wr_csr && !level2) begin
				if (wdata[`WDT_BIT_EN]) begin
					csr.en <= 1'b1; // [R05] [R19]
				end else if (unlock_open) begin
					csr.en <= 1'b0; // [R07] [R20]
				end
			end
			csr.rsvd <= 1'b0;
		end
	end

	// reset-cause flags survive every reset except power-on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause_flags <= `WDT_CAUSE_RESET; // [R14] [R11] [R12] [R13]
		end else begin
			if (wdt_fire) begin
				cause_flags.watchdog_reset_flag <= 1'b1; // [R11]
			end else if (wr_cause && !wdata[`WDT_BIT_WATCHDOG_RESET_FLAG]) begin
				cause_flags.watchdog_reset_flag <= 1'b0; // [R11]
			end
			if (bor_rise) begin
				cause_flags.brownout_reset_flag <= 1'b1; // [R12]
			end else if (wr_cause && !wdata[`WDT_BIT_BROWNOUT_RESET_FLAG]) begin
				cause_flags.brownout_reset_flag <= 1'b0; // [R12]
			end
			if (pin_rise) begin
				cause_flags.pin_reset_flag <= 1'b1; // [R13]
			end else if (wr_cause && !wdata[`WDT_BIT_PIN_RESET_FLAG]) begin
				cause_flags.pin_reset_flag <= 1'b0; // [R13]
			end
			if (wr_cause && !wdata[`WDT_BIT_POWERON_RESET_FLAG]) begin
				cause_flags.poweron_reset_flag <= 1'b0; // [R14]
			end
			cause_flags.rsvd <= 4'h0; // [R10]
		end
	end

	// outputs to the cpu core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timeout_irq <= 1'b0;
			watchdog_reset_out <= 1'b0;
		end else begin
			timeout_irq <= global_irq_enable && csr.irq_en && csr.irq_flag; // [R16]
			watchdog_reset_out <= wdt_fire; // [R04]
		end
	end

	// read mux; the enable bit shows its effective value
	always_comb begin
		read_byte = 8'h00;
		if (paddr == `WDT_CSR_ADDR) begin
			read_byte = {csr.irq_flag, csr.irq_en, csr.per_hi, 1'b0, enable_eff, csr.per_lo}; // [R10] [R06]
		end else if (paddr == `WDT_CAUSE_ADDR) begin
			read_byte = {4'h0, cause_flags[3:0]}; // [R10]
		end else if (paddr == `WDT_PROTECT_ADDR) begin
			read_byte = {7'h00, unlock_open};
		end
	end

	// every access completes with one wait-free access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup_phase;
			pslverr <= setup_phase && !mapped;
			if (setup_phase && !pwrite) begin
				prdata <= {24'h000000, read_byte};
			end
		end
	end

endmodule : watchdog_with_reset_flags

`default_nettype wire

// >>> bench/watchdog_with_reset_flags_properties.sv
`timescale 1ns/1ps
`default_nettype none
module wdt_checker (
	input wire logic pclk, // clock
	input wire logic presetn, // reset
	input wire logic psel, // apb
	input wire logic penable, // apb
	input wire logic pwrite, // apb
	input wire logic [11:0] paddr, // apb
	input wire logic [31:0] pwdata, // apb
	input wire logic [31:0] prdata, // apb
	input wire logic pready, // apb
	input wire logic brownout_reset, // cause
	input wire logic pin_reset, // cause
	input wire logic global_irq_enable, // gate
	input wire wdt_pkg::reset_cause_t cause_flags, // flags
	input wire logic timeout_irq, // irq
	input wire logic watchdog_reset_out // pulse
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_after;
		!watchdog_reset_out ##0 cause_flags.watchdog_reset_flag;
	endsequence
	property p_wd_flag; watchdog_reset_out |=> s_after; endproperty
	property p_irq_gate; timeout_irq |-> $past(global_irq_enable); endproperty
	property p_por; $fell(cause_flags.poweron_reset_flag) |->
		$past(psel && penable && pwrite && paddr == 12'h064 && !pwdata[0]); endproperty
	property p_bor; $rose(brownout_reset) |-> ##[1:8] cause_flags.brownout_reset_flag; endproperty
	property p_pin; $rose(pin_reset) |-> ##[1:8] cause_flags.pin_reset_flag; endproperty
	property p_rsvd_cause; pready && !pwrite && paddr == 12'h064 |-> prdata[7:4] == 4'h0; endproperty
	property p_rsvd_csr; pready && !pwrite && paddr == 12'h060 |-> !prdata[4]; endproperty
	property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
	a_wd_flag: assert property (p_wd_flag) else $error("wd flag");
	a_irq_gate: assert property (p_irq_gate) else $error("irq gate");
	a_por: assert property (p_por) else $error("por flag");
	a_bor: assert property (p_bor) else $error("bor flag");
	a_pin: assert property (p_pin) else $error("pin flag");
	a_rsvd_cause: assert property (p_rsvd_cause) else $error("cause rsvd");
	a_rsvd_csr: assert property (p_rsvd_csr) else $error("csr rsvd");
	a_ready: assert property (p_ready) else $error("ready");
endmodule : wdt_checker
bind watchdog_with_reset_flags wdt_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.brownout_reset(brownout_reset), .pin_reset(pin_reset), .global_irq_enable(global_irq_enable),
	.cause_flags(cause_flags), .timeout_irq(timeout_irq), .watchdog_reset_out(watchdog_reset_out));
`default_nettype wire

// >>> bench/tb_watchdog_with_reset_flags.sv
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_with_reset_flags;
	import wdt_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, osc_32k = 0, fuse = 0;
	logic restart_pulse = 0, gie = 0, ack = 0, bor = 0, pin = 0, pready, pslverr, irq, wd_rst, e;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [7:0] q;
	reset_cause_t cause_flags;
	int errors = 0, check_count = 0, cycles = 0, osc_edges = 0, resets = 0, m_cause = 1;
	integer seed = 32'hef74;
	watchdog_with_reset_flags DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .osc_32k(osc_32k), .safety_level_fuse(fuse), .restart_pulse(restart_pulse),
		.global_irq_enable(gie), .irq_vector_ack(ack), .brownout_reset(bor), .pin_reset(pin),
		.cause_flags(cause_flags), .timeout_irq(irq), .watchdog_reset_out(wd_rst));
	initial forever #12.5 pclk = ~pclk;
	// oscillator kept at 8 bus cycles so every edge is seen through the synchroniser
	always begin
		repeat (4) @(posedge pclk);
		osc_32k <= ~osc_32k;
	end
	always @(posedge osc_32k) osc_edges++;
	// cause model: set by each reset source, cleared by zero-writes, power-on leaves only bit 0
	always @(posedge pclk) if (wd_rst === 1'b1) begin
		resets++;
		m_cause = m_cause | 8;
	end
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 60000) begin
			errors++;
			wrap_up();
		end
	end
	task wrap_up;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : wrap_up
	task chk(input string n, input logic [7:0] x, input logic [7:0] g);
		check_count++;
		if (g !== x) begin
			errors++;
			$display("[ERR] %s exp %h got %h", n, x, g);
		end
	endtask : chk
	task apb(input logic [11:0] a, input logic w, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= $random(seed) & 32'hFFFFFF00 | {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata[7:0];
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task wr(input logic [11:0] a, input logic [7:0] d);
		apb(a, 1, d);
		if (a == 12'h064) m_cause = m_cause & d;
	endtask : wr
	task rd(input logic [11:0] a, input logic [7:0] x, input string n);
		apb(a, 0, 8'h00);
		chk(n, x, q);
		if (a == 12'h064) chk("cause model", m_cause[7:0], q);
	endtask : rd
	task wait_flag;
		do apb(12'h060, 0, 8'h00); while (q[7] !== 1'b1);
	endtask : wait_flag
	task settle;
		repeat (4) @(posedge pclk);
	endtask : settle
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		chk("cause", 8'h01, cause_flags);
		rd(12'h060, 8'h00, "csr");
		wr(12'h064, 8'hF0);
		rd(12'h064, 8'h00, "cause");
		apb(12'h800 | $random(seed) & 12'h7FC, 0, 8'h00);
		chk("err", 8'h01, {7'h0, e});
		osc_edges = 0;
		wr(12'h060, 8'h2A);
		while (wd_rst !== 1'b1) @(posedge pclk);
		chk("period", 8'h01, {7'h0, osc_edges >= 510 && osc_edges <= 515});
		rd(12'h064, 8'h08, "cause");
		rd(12'h060, 8'h08, "csr");
		wr(12'h068, 8'hD8);
		wr(12'h060, 8'h00);
		rd(12'h060, 8'h08, "csr");
		wr(12'h064, 8'h00);
		rd(12'h060, 8'h00, "csr");
		wr(12'h060, 8'h18);
		wr(12'h060, 8'h00);
		rd(12'h060, 8'h08, "csr");
		wr(12'h068, 8'hD7);
		wr(12'h060, 8'h00);
		rd(12'h060, 8'h08, "csr");
		wr(12'h068, 8'hD8);
		wr(12'h060, 8'h00);
		rd(12'h060, 8'h00, "csr");
		wr(12'h060, 8'h40);
		wait_flag();
		chk("irq", 8'h00, {7'h0, irq});
		gie <= 1;
		settle();
		chk("irq", 8'h01, {7'h0, irq});
		ack <= 1;
		@(posedge pclk);
		ack <= 0;
		settle();
		chk("irq", 8'h00, {7'h0, irq});
		wait_flag();
		wr(12'h060, 8'hC0);
		rd(12'h060, 8'h40, "csr");
		wr(12'h060, 8'h48);
		wait_flag();
		rd(12'h060, 8'h88, "csr");
		for (int i = 0; i < 2; i++) begin
			if (i == 0) bor <= 1;
			else pin <= 1;
			m_cause = m_cause | (i ? 2 : 4);
			repeat (10) @(posedge pclk);
			bor <= 0;
			pin <= 0;
			rd(12'h064, i ? 8'h06 : 8'h04, "cause");
			rd(12'h060, 8'h00, "csr");
		end
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		m_cause = 1;
		chk("cause", 8'h01, cause_flags);
		wr(12'h064, 8'h00);
		rd(12'h064, 8'h00, "cause");
		fuse <= 1;
		settle();
		rd(12'h060, 8'h08, "csr");
		wr(12'h068, 8'hD8);
		wr(12'h060, 8'h01);
		rd(12'h060, 8'h09, "csr");
		wr(12'h060, 8'h00);
		rd(12'h060, 8'h09, "csr");
		wr(12'h068, 8'hD8);
		wr(12'h060, 8'h00);
		rd(12'h060, 8'h08, "csr");
		wr(12'h068, 8'hD8);
		wr(12'h060, 8'h01);
		resets = 0;
		for (int k = 0; k < 3; k++) begin
			repeat (3000) @(posedge pclk);
			restart_pulse <= 1;
			@(posedge pclk);
			restart_pulse <= 0;
		end
		chk("resets", 8'h00, resets[7:0]);
		osc_edges = 0;
		while (wd_rst !== 1'b1) @(posedge pclk);
		chk("period", 8'h01, {7'h0, osc_edges >= 1021 && osc_edges <= 1026});
		rd(12'h064, 8'h08, "cause");
		rd(12'h060, 8'h08, "csr");
		wrap_up();
	end
endmodule : tb_watchdog_with_reset_flags
`default_nettype wire
